// ---- rtl/uart_ext_pkg.sv ----
// Shared constants for the extended UART block
package uart_ext_pkg;
	// Framing modes
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_9BIT_FIXED = 2'h2;
	localparam logic [1:0] MODE_9BIT_VAR = 2'h3;
	// Bit timing on the 16x sample tick
	localparam int TICKS_PER_BIT = 16;
	localparam logic [3:0] PHASE_LAST = 4'(TICKS_PER_BIT - 1);
	localparam logic [3:0] PHASE_S1 = 4'h7;
	localparam logic [3:0] PHASE_S2 = 4'h8;
	localparam logic [3:0] PHASE_S3 = 4'h9;
	// Data bits per frame
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	localparam logic [3:0] NINTH_BIT_IDX = 4'h9;
	// Break: eleven low bit times
	localparam int BREAK_BITS = 11;
	localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * TICKS_PER_BIT);
	// Line levels and widths
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_START = 1'b0;
	localparam int RX_WORD_W = 9;
	// Reset values of the address, frame, shift and counter registers
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] ADDR_MASK_RST = 8'h00;
	localparam logic [10:0] FRAME_RST = 11'h7FF;
	localparam logic [8:0] RX_SHIFT_RST = 9'h000;
	localparam logic [3:0] COUNT_RST = 4'h0;
	localparam logic [7:0] BREAK_CNT_RST = 8'h00;
endpackage : uart_ext_pkg

// ---- rtl/rx_bit_sampler.sv ----
// Receive line sampler: start detect and 2-of-3 majority bit vote
`timescale 1ns/1ps
module rx_bit_sampler
	import uart_ext_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Line and timing
	input wire logic sample_tick,
	input wire logic rxd,
	input wire logic run,
	// Results
	output logic start_stb,
	output logic bit_stb,
	output logic bit_val
);
	logic prev_r;
	logic [3:0] phase_r;
	logic s1_r;
	logic s2_r;

	// Falling edge seen while idle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_r <= LINE_IDLE;
			start_stb <= 1'b0;
		end else begin
			start_stb <= 1'b0;
			if (sample_tick) begin
				prev_r <= rxd;
				if (!run && prev_r == LINE_IDLE && rxd == LINE_START)
					start_stb <= 1'b1;
			end
		end
	end

	// Phase counter and majority vote
	always_ff @(posedge clk) begin
		if (!rstn) begin
			phase_r <= COUNT_RST;
			s1_r <= LINE_IDLE;
			s2_r <= LINE_IDLE;
			bit_stb <= 1'b0;
			bit_val <= LINE_IDLE;
		end else begin
			bit_stb <= 1'b0;
			if (!run) begin
				phase_r <= COUNT_RST;
			end else if (sample_tick) begin
				phase_r <= phase_r + 4'h1;
				if (phase_r == PHASE_S1)
					s1_r <= rxd;
				if (phase_r == PHASE_S2)
					s2_r <= rxd;
				if (phase_r == PHASE_S3) begin
					bit_stb <= 1'b1;
					bit_val <= (s1_r & s2_r) | (s1_r & rxd) | (s2_r & rxd);
				end
			end
		end
	end
endmodule : rx_bit_sampler

// ---- rtl/two_entry_buffer.sv ----
// Two-entry valid/ready buffer with registered head
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic tail_valid_r;
	logic [WIDTH-1:0] tail_data_r;
	logic push;
	logic pop;

	assign in_ready = !tail_valid_r;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			out_valid <= 1'b0;
			out_data <= '0;
			tail_valid_r <= 1'b0;
			tail_data_r <= '0;
		end else if (pop) begin
			if (tail_valid_r) begin
				out_data <= tail_data_r;
				tail_valid_r <= push;
				if (push)
					tail_data_r <= in_data;
			end else begin
				out_valid <= push;
				if (push)
					out_data <= in_data;
			end
		end else if (push) begin
			if (!out_valid) begin
				out_valid <= 1'b1;
				out_data <= in_data;
			end else begin
				tail_valid_r <= 1'b1;
				tail_data_r <= in_data;
			end
		end
	end
endmodule : two_entry_buffer

// ---- rtl/uart_dblbuf_break_addr_match.sv ----
// Extended UART: break detect, double-buffered transmit, address match
`timescale 1ns/1ps
module uart_dblbuf_break_addr_match
	import uart_ext_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Serial line
	input wire logic sample_tick,
	input wire logic rxd,
	output logic txd,
	// Configuration
	input wire logic [1:0] mode,
	input wire logic uart_enable,
	input wire logic double_buffer_enable,
	input wire logic last_tx_int_select,
	input wire logic tx_int_late,
	input wire logic multiproc_enable,
	input wire logic break_reset_enable,
	// Address registers
	input wire logic own_addr_wr,
	input wire logic slave_mask_wr,
	input wire logic [7:0] addr_wdata,
	output logic [7:0] own_slave_address,
	output logic [7:0] slave_address_mask,
	// Transmit write
	input wire logic serial_buffer_wr,
	input wire logic [7:0] serial_buffer,
	input wire logic tx_ninth_bit,
	output logic tx_hold_full,
	output logic tx_busy,
	// Transmit interrupt flag
	input wire logic tx_int_clear,
	output logic tx_int_flag,
	// Receive data
	output logic rx_valid,
	output logic [7:0] serial_buffer_n,
	output logic rx_word_ninth,
	input wire logic rx_ready,
	// Receive status
	input wire logic rx_done_clear,
	output logic rx_done_flag,
	output logic rx_ninth_bit,
	// Break status and reset request
	input wire logic break_clear,
	output logic break_flag,
	output logic in_system_programming_mode_req
);
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_BITS = 2'b01,
		TX_STOP = 2'b10
	} tx_state_type;
	typedef enum logic [0:0] {
		RX_IDLE = 1'b0,
		RX_BITS = 1'b1
	} rx_state_type;

	// Data bits per frame for a mode
	function automatic logic [3:0] data_bits(input logic [1:0] m);
		data_bits = (m == MODE_9BIT_FIXED || m == MODE_9BIT_VAR) ? DATA_BITS_9 : DATA_BITS_8;
	endfunction : data_bits

	// Given or broadcast address hit
	function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] a,
		input logic [7:0] m);
		logic [7:0] bc;
		bc = a | m;
		addr_hit = (((b ^ a) & m) == 8'h00) || ((~b & bc) == 8'h00);
	endfunction : addr_hit

	tx_state_type tx_state_r;
	rx_state_type rx_state_r;
	logic [3:0] tx_phase_r;
	logic [3:0] tx_idx_r;
	logic [10:0] tx_frame_r;
	logic tx_frame_db_r;
	logic [8:0] hold_data_r;
	logic tx_int_set;
	logic stop_begin;
	logic stop_end;
	logic tx_start_now;
	logic hold_load;
	logic [3:0] rx_idx_r;
	logic [8:0] rx_shift_r;
	logic [7:0] break_cnt_r;
	logic run;
	logic start_stb;
	logic bit_stb;
	logic bit_val;
	logic nine_bit_mode;
	logic frame_end;
	logic [7:0] rx_byte;
	logic rx_nin;
	logic mp_ok;
	logic rx_accept;
	logic buf_in_ready;
	logic [8:0] next_frame_bits;

	assign nine_bit_mode = data_bits(mode) == DATA_BITS_9;

	// Receive line sampler
	rx_bit_sampler u_sampler (
		.clk(clk),
		.rstn(rstn),
		.sample_tick(sample_tick),
		.rxd(rxd),
		.run(run),
		.start_stb(start_stb),
		.bit_stb(bit_stb),
		.bit_val(bit_val)
	);

	// Address registers, cleared to all don't-care
	always_ff @(posedge clk) begin
		if (!rstn) begin
			own_slave_address <= OWN_ADDR_RST;
			slave_address_mask <= ADDR_MASK_RST;
		end else begin
			if (own_addr_wr)
				own_slave_address <= addr_wdata;
			if (slave_mask_wr)
				slave_address_mask <= addr_wdata;
		end
	end

	// Break counter: low ticks span eleven bit times in every mode
	always_ff @(posedge clk) begin
		if (!rstn) begin
			break_cnt_r <= BREAK_CNT_RST;
			break_flag <= 1'b0;
			in_system_programming_mode_req <= 1'b0;
		end else begin
			in_system_programming_mode_req <= 1'b0;
			if (rxd != LINE_START)
				break_cnt_r <= BREAK_CNT_RST;
			else if (sample_tick && break_cnt_r != BREAK_TICKS)
				break_cnt_r <= break_cnt_r + 8'h01;
			if (sample_tick && rxd == LINE_START && break_cnt_r == BREAK_TICKS - 8'h01) begin
				break_flag <= 1'b1;
				if (uart_enable && break_reset_enable)
					in_system_programming_mode_req <= 1'b1;
			end else if (break_clear) begin
				break_flag <= 1'b0;
			end
		end
	end

	// Transmit control events
	assign tx_start_now = serial_buffer_wr && tx_state_r == TX_IDLE && !tx_hold_full;
	assign hold_load = serial_buffer_wr && double_buffer_enable && tx_state_r != TX_IDLE
		&& !tx_hold_full;
	assign stop_begin = sample_tick && tx_state_r == TX_BITS && tx_phase_r == PHASE_LAST
		&& tx_idx_r == data_bits(mode);
	assign stop_end = sample_tick && tx_state_r == TX_STOP && tx_phase_r == PHASE_LAST;
	assign next_frame_bits = {tx_ninth_bit, serial_buffer};

	// Transmit interrupt timing
	always_comb begin
		tx_int_set = 1'b0;
		if (!double_buffer_enable) begin
			tx_int_set = tx_int_late ? stop_end : stop_begin;
		end else begin
			if (tx_start_now)
				tx_int_set = 1'b1;
			if ((tx_int_late ? stop_end : stop_begin) && (tx_hold_full || hold_load))
				tx_int_set = 1'b1;
			else if ((tx_int_late ? stop_end : stop_begin) && last_tx_int_select)
				tx_int_set = 1'b1;
		end
	end

	// Transmit interrupt flag, set wins over clear
	always_ff @(posedge clk) begin
		if (!rstn)
			tx_int_flag <= 1'b0;
		else if (tx_int_set)
			tx_int_flag <= 1'b1;
		else if (tx_int_clear)
			tx_int_flag <= 1'b0;
	end

	// Double buffer holding register with ninth bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_hold_full <= 1'b0;
			hold_data_r <= RX_SHIFT_RST;
		end else if (hold_load && !stop_end) begin
			tx_hold_full <= 1'b1;
			hold_data_r <= next_frame_bits;
		end else if (stop_end && tx_hold_full) begin
			tx_hold_full <= 1'b0;
		end
	end

	// Transmit shifter
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_state_r <= TX_IDLE;
			tx_phase_r <= COUNT_RST;
			tx_idx_r <= COUNT_RST;
			tx_frame_r <= FRAME_RST;
			tx_frame_db_r <= 1'b0;
			txd <= LINE_IDLE;
			tx_busy <= 1'b0;
		end else begin
			if (sample_tick && tx_state_r != TX_IDLE)
				tx_phase_r <= tx_phase_r + 4'h1;
			unique case (tx_state_r)
				TX_IDLE: begin
					if (tx_start_now) begin
						tx_state_r <= TX_BITS;
						tx_phase_r <= COUNT_RST;
						tx_idx_r <= COUNT_RST;
						tx_frame_r <= {LINE_IDLE, next_frame_bits, LINE_START};
						tx_frame_db_r <= double_buffer_enable;
						txd <= LINE_START;
						tx_busy <= 1'b1;
					end
				end
				TX_BITS: begin
					if (sample_tick && tx_phase_r == PHASE_LAST) begin
						tx_idx_r <= tx_idx_r + 4'h1;
						tx_frame_r <= {LINE_IDLE, tx_frame_r[10:1]};
						if (stop_begin) begin
							tx_state_r <= TX_STOP;
							txd <= LINE_IDLE;
						end else if (tx_idx_r + 4'h1 == NINTH_BIT_IDX && !tx_frame_db_r) begin
							txd <= tx_ninth_bit;
						end else begin
							txd <= tx_frame_r[1];
						end
					end
				end
				TX_STOP: begin
					if (stop_end) begin
						if (tx_hold_full || hold_load) begin
							tx_state_r <= TX_BITS;
							tx_idx_r <= COUNT_RST;
							tx_frame_r <= {LINE_IDLE, tx_hold_full ? hold_data_r : next_frame_bits,
								LINE_START};
							tx_frame_db_r <= 1'b1;
							txd <= LINE_START;
						end else begin
							tx_state_r <= TX_IDLE;
							tx_busy <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// Receive frame decode
	assign run = rx_state_r == RX_BITS;
	assign frame_end = bit_stb && run && rx_idx_r == data_bits(mode) + 4'h1;
	assign rx_byte = rx_shift_r[7:0];
	assign rx_nin = nine_bit_mode ? rx_shift_r[8] : bit_val;

	// Multiprocessor and address gating
	always_comb begin
		mp_ok = 1'b1;
		if (mode == MODE_8BIT)
			mp_ok = !multiproc_enable || bit_val;
		else if (nine_bit_mode && multiproc_enable)
			mp_ok = rx_nin && addr_hit(rx_byte, own_slave_address,
				slave_address_mask);
	end

	assign rx_accept = frame_end && !rx_done_flag && mp_ok && buf_in_ready;

	// Receive shifter
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_state_r <= RX_IDLE;
			rx_idx_r <= COUNT_RST;
			rx_shift_r <= RX_SHIFT_RST;
		end else begin
			unique case (rx_state_r)
				RX_IDLE: begin
					if (start_stb) begin
						rx_state_r <= RX_BITS;
						rx_idx_r <= COUNT_RST;
					end
				end
				RX_BITS: begin
					if (bit_stb) begin
						rx_idx_r <= rx_idx_r + 4'h1;
						if (rx_idx_r == COUNT_RST && bit_val != LINE_START)
							rx_state_r <= RX_IDLE;
						else if (frame_end)
							rx_state_r <= RX_IDLE;
						else if (rx_idx_r != COUNT_RST)
							rx_shift_r[rx_idx_r - 4'h1] <= bit_val;
					end
				end
			endcase
		end
	end

	// Receive flags, set wins over clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rx_done_flag <= 1'b0;
			rx_ninth_bit <= 1'b0;
		end else if (rx_accept) begin
			rx_done_flag <= 1'b1;
			rx_ninth_bit <= rx_nin;
		end else if (rx_done_clear) begin
			rx_done_flag <= 1'b0;
		end
	end

	// Received words toward the reader
	two_entry_buffer #(
		.WIDTH(RX_WORD_W)
	) u_rx_buf (
		.clk(clk),
		.rstn(rstn),
		.in_valid(rx_accept),
		.in_data({rx_nin, rx_byte}),
		.in_ready(buf_in_ready),
		.out_valid(rx_valid),
		.out_data({rx_word_ninth, serial_buffer_n}),
		.out_ready(rx_ready)
	);
endmodule : uart_dblbuf_break_addr_match

// ---- testbench/uart_ext_props.sv ----
// Checker for the extended UART ports
`timescale 1ns/1ps
module uart_ext_props
	import uart_ext_pkg::*;
(
	// Clock, reset and line
	input wire logic clk,
	input wire logic rstn,
	input wire logic sample_tick,
	input wire logic rxd,
	input wire logic txd,
	// Controls
	input wire logic uart_enable,
	input wire logic double_buffer_enable,
	input wire logic break_reset_enable,
	input wire logic serial_buffer_wr,
	input wire logic tx_int_clear,
	input wire logic rx_done_clear,
	input wire logic break_clear,
	// Status
	input wire logic [7:0] own_slave_address,
	input wire logic [7:0] slave_address_mask,
	input wire logic tx_hold_full,
	input wire logic tx_busy,
	input wire logic tx_int_flag,
	input wire logic rx_done_flag,
	input wire logic rx_ninth_bit,
	input wire logic break_flag,
	input wire logic in_system_programming_mode_req
);
	logic [7:0] low_r;
	// Ticks of low receive line
	always_ff @(posedge clk) begin
		if (!rstn || rxd) begin
			low_r <= 8'h00;
		end else if (sample_tick && low_r != 8'hFF) begin
			low_r <= low_r + 8'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	break_set_a: assert property ($rose(break_flag) |-> low_r >= 8'hAF)
		else $error("break flag set early");
	break_sticky_a: assert property (break_flag && !break_clear |=> break_flag)
		else $error("break flag lost");
	isp_gate_a: assert property (in_system_programming_mode_req
		|-> $past(uart_enable) && $past(break_reset_enable))
		else $error("reset request not gated");
	idle_start_a: assert property (!tx_busy && serial_buffer_wr |=> tx_busy && !txd)
		else $error("no start bit after write");
	idle_line_a: assert property (!tx_busy |-> txd)
		else $error("line low while idle");
	single_hold_a: assert property (!double_buffer_enable && !tx_busy |-> !tx_hold_full)
		else $error("hold used single buffered");
	dbl_int_a: assert property (double_buffer_enable && !tx_busy && !tx_hold_full
		&& serial_buffer_wr |-> ##[1:2] tx_int_flag)
		else $error("no immediate interrupt");
	int_sticky_a: assert property (tx_int_flag && !tx_int_clear |=> tx_int_flag)
		else $error("interrupt flag lost");
	rx_keep_a: assert property (rx_done_flag && !rx_done_clear
		|=> rx_done_flag && $stable(rx_ninth_bit))
		else $error("receive status overwritten");
	addr_reset_a: assert property ($rose(rstn) |-> own_slave_address == 8'h00
		&& slave_address_mask == 8'h00)
		else $error("address registers not cleared");
	cover property ($rose(break_flag));
	cover property ($rose(tx_hold_full));
	cover property ($rose(in_system_programming_mode_req));
endmodule : uart_ext_props
bind uart_dblbuf_break_addr_match uart_ext_props props (.clk, .rstn, .sample_tick, .rxd, .txd,
	.uart_enable, .double_buffer_enable, .break_reset_enable, .serial_buffer_wr, .tx_int_clear,
	.rx_done_clear, .break_clear, .own_slave_address, .slave_address_mask, .tx_hold_full,
	.tx_busy, .tx_int_flag, .rx_done_flag, .rx_ninth_bit, .break_flag,
	.in_system_programming_mode_req);

// ---- testbench/serial_station.sv ----
// Remote serial station: frame sender and line decoder
`timescale 1ns/1ps
module serial_station (
	// Clock and timing
	input wire logic clk,
	input wire logic sample_tick,
	// Line
	input wire logic txd,
	input wire logic nine,
	output logic rxd
);
	logic [8:0] q [$];
	initial rxd = 1'b1;
	task automatic tk(input int n);
		repeat (n) @(posedge clk iff sample_tick);
	endtask : tk
	// Frame out, LSB first, two stop bits
	task automatic send(input logic [8:0] w, input int nb);
		int i;
		rxd <= 1'b0;
		tk(16);
		for (i = 0; i < nb; i++) begin
			rxd <= w[i];
			tk(16);
		end
		rxd <= 1'b1;
		tk(32);
		@(negedge clk);
	endtask : send
	task automatic hold_low(input int n);
		rxd <= 1'b0;
		tk(n);
		rxd <= 1'b1;
		tk(32);
		@(negedge clk);
	endtask : hold_low
	// Decode frames at mid-bit
	always begin : decode
		logic [8:0] w;
		int i;
		@(negedge txd);
		w = 9'h000;
		tk(8);
		for (i = 0; i < (nine ? 9 : 8); i++) begin
			tk(16);
			w[i] = txd;
		end
		tk(16);
		q.push_back(w);
	end
endmodule : serial_station

// ---- testbench/uart_dblbuf_break_addr_match_tb.sv ----
// Testbench for the extended UART block
`timescale 1ns/1ps
module uart_dblbuf_break_addr_match_tb;
	import uart_ext_pkg::*;
	logic clk, rstn, sample_tick, rxd, txd, uart_enable, double_buffer_enable;
	logic last_tx_int_select, tx_int_late, multiproc_enable, break_reset_enable;
	logic own_addr_wr, slave_mask_wr, serial_buffer_wr, tx_ninth_bit, tx_hold_full, tx_busy;
	logic tx_int_clear, tx_int_flag, rx_valid, rx_word_ninth, rx_ready, rx_done_clear;
	logic rx_done_flag, rx_ninth_bit, break_clear, break_flag, in_system_programming_mode_req;
	logic [1:0] mode;
	logic [7:0] addr_wdata, own_slave_address, slave_address_mask, serial_buffer, serial_buffer_n;
	logic isp_seen;
	int i, num_errors, check_count;
	logic [9:0] tbl [5] = '{10'h0C0, 10'h3C2, 10'h1C4, 10'h3FD, 10'h3C0};
	uart_dblbuf_break_addr_match dut (.clk, .rstn, .sample_tick, .rxd, .txd, .mode,
		.uart_enable, .double_buffer_enable, .last_tx_int_select, .tx_int_late,
		.multiproc_enable, .break_reset_enable, .own_addr_wr, .slave_mask_wr, .addr_wdata,
		.own_slave_address, .slave_address_mask, .serial_buffer_wr, .serial_buffer,
		.tx_ninth_bit, .tx_hold_full, .tx_busy, .tx_int_clear, .tx_int_flag, .rx_valid,
		.serial_buffer_n, .rx_word_ninth, .rx_ready, .rx_done_clear, .rx_done_flag,
		.rx_ninth_bit, .break_clear, .break_flag, .in_system_programming_mode_req);
	serial_station station (.clk, .sample_tick, .txd, .nine(mode[1]), .rxd);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) sample_tick <= (sample_tick !== 1'b1);
	always @(posedge clk) begin
		isp_seen <= rstn && (isp_seen || in_system_programming_mode_req);
	end
	task chk(input string nm, input logic [8:0] s, input logic [8:0] e);
		check_count++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict
	task wt(input int s);
		int k;
		for (k = 0; k < 9000; k++) begin
			@(negedge clk);
			if (s == 1 && tx_int_flag === 1'b1) return;
			if (s == 2 && tx_busy === 1'b0) return;
		end
		num_errors++;
		print_verdict();
	endtask : wt
	task wr(input logic [8:0] w);
		tx_ninth_bit = w[8];
		@(negedge clk);
		serial_buffer = w[7:0];
		serial_buffer_wr = 1'b1;
		@(negedge clk);
		serial_buffer_wr = 1'b0;
	endtask : wr
	task clr();
		@(negedge clk);
		{tx_int_clear, rx_done_clear, rx_ready} = 3'h7;
		@(negedge clk);
		{tx_int_clear, rx_done_clear, rx_ready} = 3'h0;
	endtask : clr
	task rx(input logic [8:0] w, input logic ok);
		station.send(w, mode[1] ? 9 : 8);
		chk("rx_flag", 9'(rx_done_flag), 9'(ok));
		if (ok) begin
			chk("rx_byte", 9'(serial_buffer_n), 9'(w[7:0]));
			chk("rx_ninth", 9'(rx_ninth_bit), 9'(w[8]));
			chk("rx_word9", 9'(rx_word_ninth), 9'(w[8]));
		end
		clr();
	endtask : rx
	initial begin
		{rstn, own_addr_wr, slave_mask_wr, serial_buffer_wr, tx_int_clear} = 5'h00;
		{rx_done_clear, rx_ready, break_clear, tx_ninth_bit} = 4'h0;
		{uart_enable, double_buffer_enable, last_tx_int_select, tx_int_late} = 4'h0;
		{multiproc_enable, break_reset_enable} = 2'h0;
		{mode, addr_wdata, serial_buffer} = {MODE_8BIT, 16'h0000};
		num_errors = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk("own_rst", 9'(own_slave_address), 9'h000);
		chk("mask_rst", 9'(slave_address_mask), 9'h000);
		$display("test reset done");
		wr(9'h0A5);
		wr(9'h03C);
		chk("hold_single", 9'(tx_hold_full), 9'h000);
		wt(1);
		chk("int_stop_start", 9'({txd, tx_busy}), 9'h003);
		wt(2);
		clr();
		chk("frames", 9'(station.q.size()), 9'h001);
		chk("frame0", station.q.pop_front(), 9'h0A5);
		mode = MODE_9BIT_VAR;
		wr(9'h0A5);
		tx_ninth_bit = 1'b1;
		wt(2);
		clr();
		chk("frame_ninth", station.q.pop_front(), 9'h1A5);
		$display("test single buffer done");
		double_buffer_enable = 1'b1;
		tx_int_late = 1'b1;
		wr(9'h1C3);
		@(negedge clk);
		chk("int_now", 9'(tx_int_flag), 9'h001);
		clr();
		wr(9'h03C);
		chk("hold_full", 9'(tx_hold_full), 9'h001);
		wt(1);
		repeat (2) @(negedge clk);
		chk("reload", 9'({tx_hold_full, txd}), 9'h000);
		clr();
		wt(2);
		chk("no_last_int", 9'(tx_int_flag), 9'h000);
		chk("frame1", station.q.pop_front(), 9'h1C3);
		chk("frame2", station.q.pop_front(), 9'h03C);
		last_tx_int_select = 1'b1;
		tx_int_late = 1'b0;
		wr(9'h155);
		clr();
		wt(1);
		chk("last_int", 9'({txd, tx_busy}), 9'h003);
		wt(2);
		clr();
		chk("frame3", station.q.pop_front(), 9'h155);
		$display("test double buffer done");
		mode = MODE_9BIT_FIXED;
		double_buffer_enable = 1'b0;
		rx(9'h05A, 1'b1);
		multiproc_enable = 1'b1;
		@(negedge clk);
		addr_wdata = 8'hC0;
		own_addr_wr = 1'b1;
		@(negedge clk);
		{own_addr_wr, slave_mask_wr, addr_wdata} = {2'h1, 8'hFD};
		@(negedge clk);
		slave_mask_wr = 1'b0;
		chk("addr_wr", 9'(own_slave_address ^ slave_address_mask), 9'h03D);
		for (i = 0; i < 5; i++) rx(tbl[i][8:0], tbl[i][9]);
		$display("test address match done");
		{mode, multiproc_enable} = {MODE_8BIT, 1'b0};
		for (i = 1; i < 4; i++) begin
			station.send(9'(i), 8);
			rx_done_clear = 1'b1;
			@(negedge clk);
			rx_done_clear = 1'b0;
		end
		for (i = 1; i < 3; i++) begin
			chk("rx_head", {rx_valid, serial_buffer_n}, 9'(i) | 9'h100);
			clr();
		end
		chk("rx_empty", 9'(rx_valid), 9'h000);
		$display("test receive buffer done");
		{uart_enable, break_reset_enable} = 2'h3;
		station.hold_low(160);
		clr();
		chk("no_break", 9'(break_flag), 9'h000);
		chk("no_isp", 9'(isp_seen), 9'h000);
		station.hold_low(180);
		chk("break", 9'(break_flag), 9'h001);
		chk("isp_req", 9'(isp_seen), 9'h001);
		break_clear = 1'b1;
		@(negedge clk);
		break_clear = 1'b0;
		@(negedge clk);
		chk("break_clr", 9'(break_flag), 9'h000);
		$display("test break done");
		print_verdict();
	end
endmodule : uart_dblbuf_break_addr_match_tb
